// ---- core/bsc_regs.sv ----
// System controller register bank: keys, power, lamps, front light, restart
//
// Functional notes
// R01 - Key held unchanged for repeat interval sets repeat flag; interrupt if enabled
// R02 - Repeat flag stays set until host writes 0 while it reads 1
// R03 - Power switch held 2 s sets power switch flag; interrupt if enabled
// R04 - Power switch flag clears only on host write 0 while set
// R05 - Several keys pressed set all pattern bits and the press event
// R06 - Pattern change while keys held raises a new press event
// R07 - Releasing held keys raises the release event
// R08 - Pattern keeps the states from just before a release
// R09 - Key summary bit D2 is 1 while any key or switch flag is 1
// R10 - Key summary bit clears on host write 0 while it reads 1
// R11 - Power summary bit always reads 0
// R12 - While powered off, 2 s switch press turns system power on
// R13 - System power bit drives power, resets to 1, host write 0 turns off
// R14 - DIP switch on keeps system powered from controller power up
// R15 - Off source bit: 0 host turns off, 1 switch press turns off
// R16 - Lamp register bits 7..0 drive lamps eight to one
// R17 - Lamps show firmware version pattern after power up
// R18 - Front light bit 0 on, 1 off, resets to 1
// R19 - Restart control register is a byte at its own offset
// R20 - Keys sampled every 10 ms, accepted after three equal samples
// R21 - Key on sets press flag, key off sets release flag
// R22 - Writing 1 to restart bit restarts the system
// R23 - Scope bit selects reset switch reach, register resets to 0x02
// R24 - Interrupt request high while any flag and its enable are 1
// R25 - Reserved bits read 0 and ignore writes
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
`include "bsc_consts.svh"
`default_nettype none

module bsc_regs #(
  parameter int unsigned SAMPLE_CYCLES = `BSC_SAMPLE_CYCLES,
  parameter logic [7:0] FW_VERSION = 8'h01 // Arbitrary value
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire bsc_pkg::bsc_bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire logic [6:0] key_in,
  input wire logic power_switch_in,
  input wire logic dip_power_in,
  output logic irq,
  output logic system_power_on,
  output logic [7:0] indicator_lamp_n,
  output logic front_light_off,
  output logic system_restart,
  output logic switch_reset_scope,
  output logic [15:0] key_pattern
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0] dip_fill;
    logic dip_done;
    logic [31:0] tick_cnt;
    logic tick;
    logic [6:0] samp0;
    logic [6:0] samp1;
    logic [6:0] stable;
    logic [6:0] pattern;
    logic [7:0] rep_cnt;
    logic [7:0] hold_cnt;
    bsc_pkg::bsc_pwr_state_t pwr_state;
    logic [7:0] key_ctrl;
    logic [7:0] repeat_int;
    logic press_flag;
    logic release_flag;
    logic repeat_flag;
    logic pswitch_flag;
    logic summary_flag;
    logic pwr_src;
    logic [7:0] lamps;
    logic front;
    logic scope;
    logic restart_bit;
    logic restart_pulse;
    logic irq;
    logic [7:0] rdata;
  } bsc_state_t;

  bsc_state_t st_reg;
  bsc_state_t st_next;

  // ==========================================================
  // Helpers
  function automatic logic [15:0] map_pattern(input logic [6:0] k);
    map_pattern = {5'h00, k[6], 1'b0, k[5], 3'h0, k[4:0]};
  endfunction : map_pattern

  // Lowest set bit of the interval register wins; zero disables repeat
  function automatic logic [7:0] repeat_ticks(input logic [7:0] r);
    repeat_ticks = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      if (r[i]) begin
        repeat_ticks = 8'((`BSC_REPEAT_BASE_MS + `BSC_REPEAT_STEP_MS * i) / `BSC_SAMPLE_MS);
      end
    end
  endfunction : repeat_ticks

  logic wr_hit;
  logic pressed;
  logic released;
  logic [7:0] rep_limit;
  logic sw_done;
  logic rep_hit;
  logic [15:0] pat_map;
  logic [6:0] key_sync;
  logic pwr_sync;
  logic dip_sync;

  // ==========================================================
  // Pin synchronisers
  bsc_sync #(.WIDTH(7)) key_syncer (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin_in(key_in),
    .pin_sync(key_sync)
  );

  bsc_sync #(.WIDTH(1)) pwr_syncer (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin_in(power_switch_in),
    .pin_sync(pwr_sync)
  );

  bsc_sync #(.WIDTH(1)) dip_syncer (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin_in(dip_power_in),
    .pin_sync(dip_sync)
  );

  always_comb begin
    st_next = st_reg;
    wr_hit = bus_req.wr;
    pressed = 1'b0;
    released = 1'b0;
    rep_limit = repeat_ticks(st_reg.repeat_int);
    sw_done = 1'b0;
    rep_hit = 1'b0;
    pat_map = map_pattern(st_reg.pattern);
    st_next.dip_fill = {st_reg.dip_fill[0], 1'b1};

    // ==========================================================
    // Sample tick and debounce
    st_next.tick = 1'b0;
    if (st_reg.tick_cnt >= SAMPLE_CYCLES - 1) begin // R20
      st_next.tick_cnt = 32'h0000_0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 32'h0000_0001;
    end

    if (st_reg.tick) begin
      st_next.samp0 = key_sync;
      st_next.samp1 = st_reg.samp0;
      if (st_reg.key_ctrl[`BSC_KC_INPUT_EN] && key_sync == st_reg.samp0 &&
          st_reg.samp0 == st_reg.samp1 && key_sync != st_reg.stable) begin // R20
        st_next.stable = key_sync;
        // Any key on or a new held combination counts as a press
        pressed = |(key_sync & ~st_reg.stable) ||
                  (|key_sync && |st_reg.stable); // R05 R06 R21
        released = |(~key_sync & st_reg.stable); // R07 R21
        // All-released keeps the last held combination visible
        if (|key_sync) begin
          st_next.pattern = key_sync; // R05 R08
        end
        st_next.rep_cnt = 8'h00;
      end else if (|st_reg.stable && rep_limit != 8'h00) begin
        if (st_reg.rep_cnt + 8'h01 >= rep_limit) begin
          st_next.rep_cnt = 8'h00;
          rep_hit = 1'b1; // R01
        end else begin
          st_next.rep_cnt = st_reg.rep_cnt + 8'h01;
        end
      end

      // ==========================================================
      // Power switch hold timer
      if (pwr_sync) begin
        if (st_reg.hold_cnt < 8'(`BSC_PWR_HOLD_TICKS)) begin
          st_next.hold_cnt = st_reg.hold_cnt + 8'h01;
          sw_done = (st_reg.hold_cnt + 8'h01 == 8'(`BSC_PWR_HOLD_TICKS)); // R03 R12
        end
      end else begin
        st_next.hold_cnt = 8'h00;
      end
    end

    // ==========================================================
    // Power state
    case (st_reg.pwr_state)
      bsc_pkg::BSC_PWR_OFF: begin
        if (sw_done) begin
          st_next.pwr_state = bsc_pkg::BSC_PWR_HOLD; // R12
        end
      end
      bsc_pkg::BSC_PWR_ON: begin
        if (sw_done && st_reg.pwr_src) begin
          st_next.pwr_state = bsc_pkg::BSC_PWR_OFF; // R15
        end
      end
      bsc_pkg::BSC_PWR_HOLD: begin
        // The press that switched power on must end before it can switch it off
        if (!pwr_sync) begin
          st_next.pwr_state = bsc_pkg::BSC_PWR_ON;
        end
      end
      default: begin
        st_next.pwr_state = bsc_pkg::BSC_PWR_OFF;
      end
    endcase

    // Strap is read once, after the synchroniser has filled
    if (!st_reg.dip_done && st_reg.dip_fill[1]) begin
      st_next.dip_done = 1'b1;
      if (!dip_sync) begin
        st_next.pwr_state = bsc_pkg::BSC_PWR_OFF; // R14
      end
    end

    // ==========================================================
    // Register writes; sticky flags: a write 0 clears, hardware set wins
    st_next.restart_pulse = 1'b0;
    if (wr_hit) begin
      case (bus_req.addr)
        `BSC_KEY_CTRL_OFS: st_next.key_ctrl = {2'b00, bus_req.wdata[5:0]}; // R25
        `BSC_REPEAT_INT_OFS: st_next.repeat_int = bus_req.wdata;
        `BSC_KEY_FLAG_OFS: begin
          if (!bus_req.wdata[`BSC_KF_PRESS]) begin
            st_next.press_flag = 1'b0;
          end
          if (!bus_req.wdata[`BSC_KF_RELEASE]) begin
            st_next.release_flag = 1'b0;
          end
          if (!bus_req.wdata[`BSC_KF_REPEAT]) begin
            st_next.repeat_flag = 1'b0; // R02
          end
          if (!bus_req.wdata[`BSC_KF_PSWITCH]) begin
            st_next.pswitch_flag = 1'b0; // R04
          end
        end
        `BSC_SUMMARY_OFS: begin
          if (!bus_req.wdata[`BSC_SUM_KEY]) begin
            st_next.summary_flag = 1'b0; // R10
          end
        end
        `BSC_SYS_PWR_OFS: begin
          if (!bus_req.wdata[0]) begin
            st_next.pwr_state = bsc_pkg::BSC_PWR_OFF; // R13
          end
        end
        `BSC_PWR_SRC_OFS: st_next.pwr_src = bus_req.wdata[0]; // R15
        `BSC_LAMPS_OFS: st_next.lamps = bus_req.wdata; // R16
        `BSC_FRONT_OFS: st_next.front = bus_req.wdata[0]; // R18
        `BSC_RESTART_OFS: begin
          st_next.restart_bit = bus_req.wdata[`BSC_RC_RESTART]; // R19
          st_next.restart_pulse = bus_req.wdata[`BSC_RC_RESTART]; // R22
          st_next.scope = bus_req.wdata[`BSC_RC_SCOPE]; // R23
        end
        default: begin
        end
      endcase
    end

    // Hardware sets after the clears so an event in a clear cycle survives
    if (pressed) begin
      st_next.press_flag = 1'b1; // R05 R06 R21
    end
    if (released) begin
      st_next.release_flag = 1'b1; // R07 R21
    end
    if (sw_done) begin
      st_next.pswitch_flag = 1'b1; // R03
    end
    if (rep_hit) begin
      st_next.repeat_flag = 1'b1; // R01
    end
    if (st_reg.press_flag || st_reg.release_flag || st_reg.repeat_flag ||
        st_reg.pswitch_flag || pressed || released || rep_hit || sw_done) begin
      st_next.summary_flag = 1'b1; // R09
    end

    st_next.irq = (st_next.press_flag && st_reg.key_ctrl[`BSC_KC_PRESS_EN]) ||
                  (st_next.release_flag && st_reg.key_ctrl[`BSC_KC_RELEASE_EN]) ||
                  (st_next.repeat_flag && st_reg.key_ctrl[`BSC_KC_REPEAT_EN]) ||
                  (st_next.pswitch_flag && st_reg.key_ctrl[`BSC_KC_PSWITCH_EN]); // R24

    // ==========================================================
    // Read data, valid in the cycle after the strobe only
    st_next.rdata = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        `BSC_KEY_CTRL_OFS: st_next.rdata = st_reg.key_ctrl;
        `BSC_REPEAT_INT_OFS: st_next.rdata = st_reg.repeat_int;
        `BSC_KEY_FLAG_OFS: st_next.rdata = {3'h0, st_reg.pswitch_flag, st_reg.repeat_flag,
                                            st_reg.release_flag, st_reg.press_flag, 1'b0}; // R25
        `BSC_PATTERN_LO_OFS: st_next.rdata = pat_map[7:0];
        `BSC_PATTERN_HI_OFS: st_next.rdata = pat_map[15:8];
        `BSC_SUMMARY_OFS: st_next.rdata = {5'h00, st_reg.summary_flag, 2'b00}; // R09 R11
        `BSC_SYS_PWR_OFS: st_next.rdata = {7'h00, st_reg.pwr_state != bsc_pkg::BSC_PWR_OFF};
        `BSC_PWR_SRC_OFS: st_next.rdata = {7'h00, st_reg.pwr_src};
        `BSC_LAMPS_OFS: st_next.rdata = st_reg.lamps;
        `BSC_FRONT_OFS: st_next.rdata = {7'h00, st_reg.front};
        `BSC_RESTART_OFS: st_next.rdata = {6'h00, st_reg.scope, st_reg.restart_bit};
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.pwr_state <= bsc_pkg::BSC_PWR_ON; // R13
      st_reg.key_ctrl <= `BSC_KEY_CTRL_RST;
      st_reg.repeat_int <= `BSC_REPEAT_INT_RST;
      st_reg.pwr_src <= `BSC_PWR_SRC_RST; // R15
      st_reg.lamps <= FW_VERSION; // R17
      st_reg.front <= `BSC_FRONT_RST; // R18
      st_reg.scope <= 1'(`BSC_RESTART_RST >> `BSC_RC_SCOPE); // R23
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata = st_reg.rdata;
  assign irq = st_reg.irq;
  // Bit 0 of the state code is high in both powered states
  assign system_power_on = st_reg.pwr_state[0]; // R13
  assign indicator_lamp_n = st_reg.lamps; // R16
  assign front_light_off = st_reg.front; // R18
  assign system_restart = st_reg.restart_pulse; // R22
  assign switch_reset_scope = st_reg.scope; // R23
  assign key_pattern = map_pattern(st_reg.pattern);

endmodule : bsc_regs

// ==========================================================
// Two-flop synchroniser for pins from outside the clock domain
module bsc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } bsc_sync_state_t;

  bsc_sync_state_t st_reg;
  bsc_sync_state_t st_next;

  // Only the second stage is read, so a metastable first stage never fans out
  always_comb begin
    st_next.stage1 = pin_in;
    st_next.stage2 = st_reg.stage1;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pin_sync = st_reg.stage2;

endmodule : bsc_sync

`default_nettype wire

// ---- core/bsc_consts.svh ----
// Offsets, field positions, reset values and timing figures of the system controller
`ifndef BSC_CONSTS_SVH
`define BSC_CONSTS_SVH

// ==========================================================
// Register offsets
`define BSC_KEY_CTRL_OFS 8'h60
`define BSC_REPEAT_INT_OFS 8'h61
`define BSC_KEY_FLAG_OFS 8'h62
`define BSC_PATTERN_LO_OFS 8'h64
`define BSC_PATTERN_HI_OFS 8'h65
`define BSC_SYS_PWR_OFS 8'h70
`define BSC_PWR_SRC_OFS 8'h71
`define BSC_SUMMARY_OFS 8'h90
`define BSC_LAMPS_OFS 8'ha0
`define BSC_FRONT_OFS 8'ha1
`define BSC_RESTART_OFS 8'ha2

// ==========================================================
// Field positions
`define BSC_KC_INPUT_EN 0
`define BSC_KC_PRESS_EN 1
`define BSC_KC_RELEASE_EN 2
`define BSC_KC_REPEAT_EN 3
`define BSC_KC_PSWITCH_EN 4
`define BSC_KF_PRESS 1
`define BSC_KF_RELEASE 2
`define BSC_KF_REPEAT 3
`define BSC_KF_PSWITCH 4
`define BSC_SUM_KEY 2
`define BSC_RC_RESTART 0
`define BSC_RC_SCOPE 1

// ==========================================================
// Reset values
`define BSC_KEY_CTRL_RST 8'h20
`define BSC_REPEAT_INT_RST 8'h01
`define BSC_SYS_PWR_RST 1'b1
`define BSC_PWR_SRC_RST 1'b1
`define BSC_FRONT_RST 1'b1
`define BSC_RESTART_RST 8'h02

// ==========================================================
// Timing
`define BSC_CLK_PERIOD_NS 10
`define BSC_SAMPLE_MS 10
`define BSC_SAMPLE_CYCLES ((`BSC_SAMPLE_MS * 1000000) / `BSC_CLK_PERIOD_NS)
`define BSC_PWR_HOLD_MS 2000
`define BSC_PWR_HOLD_TICKS ((`BSC_PWR_HOLD_MS + `BSC_SAMPLE_MS - 1) / `BSC_SAMPLE_MS)
`define BSC_REPEAT_BASE_MS 100
`define BSC_REPEAT_STEP_MS 50
`define BSC_STABLE_SAMPLES 3

`endif

// ---- core/bsc_pkg.sv ----
// Types shared by the system controller register bank
package bsc_pkg;

  typedef enum logic [1:0] {
    BSC_PWR_OFF = 2'b00,
    BSC_PWR_ON = 2'b01,
    BSC_PWR_HOLD = 2'b11
  } bsc_pwr_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bsc_bus_req_t;

endpackage : bsc_pkg

// ---- bench/bsc_panel.sv ----
// Front panel model: application keys, power switch and power strap
`timescale 1ns/1ns
`default_nettype none
module bsc_panel (
  input wire logic core_clk,
  input wire logic [6:0] key_cmd,
  input wire logic sw_cmd,
  input wire logic dip_cmd,
  output logic [6:0] key_in,
  output logic power_switch_in,
  output logic dip_power_in
);
  // ==========================================================
  // Contacts
  // Clean levels only: bounce would need longer holds than the run can afford
  always_ff @(posedge core_clk) begin
    key_in <= key_cmd;
    power_switch_in <= sw_cmd;
    dip_power_in <= dip_cmd;
  end
endmodule : bsc_panel
`default_nettype wire

// ---- bench/bsc_regs_checker.sv ----
// Port assertions for the system controller register bank
`timescale 1ns/1ns
`default_nettype none
module bsc_regs_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire bsc_pkg::bsc_bus_req_t bus_req,
  input wire logic [7:0] rdata,
  input wire logic system_power_on,
  input wire logic [7:0] indicator_lamp_n,
  input wire logic front_light_off,
  input wire logic system_restart,
  input wire logic switch_reset_scope
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Bus steps
  sequence wr_at(logic [7:0] a);
    bus_req.wr && bus_req.addr == a;
  endsequence
  sequence rd_at(logic [7:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  lamp_write_a: assert property (
    wr_at(8'ha0) |=> indicator_lamp_n == $past(bus_req.wdata)) else $error("lamp write lost");
  front_write_a: assert property (
    wr_at(8'ha1) |=> front_light_off == $past(bus_req.wdata[0])) else $error("front light");
  scope_write_a: assert property (
    wr_at(8'ha2) |=> switch_reset_scope == $past(bus_req.wdata[1])) else $error("scope bit");
  restart_pulse_a: assert property (
    wr_at(8'ha2) ##0 bus_req.wdata[0] |=> system_restart ##1 !system_restart)
    else $error("restart pulse");
  power_off_a: assert property (
    wr_at(8'h70) ##0 !bus_req.wdata[0] |=> !system_power_on) else $error("power stays on");
  power_read_a: assert property (
    rd_at(8'h70) |=> rdata == {7'h00, $past(system_power_on)}) else $error("power readback");
  summary_read_a: assert property (
    rd_at(8'h90) |=> rdata[7:5] == 3'h0 && !rdata[3]) else $error("summary reserved bits");
  rdata_idle_a: assert property (
    !bus_req.rd |=> rdata == 8'h00) else $error("read data outside read");
endmodule : bsc_regs_checker
bind bsc_regs bsc_regs_checker chk (.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req),
  .rdata(rdata), .system_power_on(system_power_on), .indicator_lamp_n(indicator_lamp_n),
  .front_light_off(front_light_off), .system_restart(system_restart),
  .switch_reset_scope(switch_reset_scope));
`default_nettype wire

// ---- bench/bsc_regs_tb.sv ----
// Self-checking bench for the system controller register bank
`timescale 1ns/1ns
`default_nettype none
module bsc_regs_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  bsc_pkg::bsc_bus_req_t bus_req = '0;
  logic [7:0] rdata;
  logic [7:0] indicator_lamp_n;
  logic [15:0] key_pattern;
  logic [6:0] key_in;
  logic [6:0] key_cmd = '0;
  logic irq, system_power_on, front_light_off, system_restart, switch_reset_scope;
  logic power_switch_in, dip_power_in;
  logic sw_cmd = 1'b0;
  logic dip_cmd = 1'b1;
  logic pend = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] seed = 8'h5d;
  logic [6:0] kseq[3] = '{7'h03, 7'h07, 7'h00};
  logic [7:0] kflag[3] = '{8'h02, 8'h02, 8'h04};
  logic [7:0] kpat[3] = '{8'h03, 8'h07, 8'h07};
  int errors = 0;
  int n_checks = 0;
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  bsc_panel panel (.core_clk(core_clk), .key_cmd(key_cmd), .sw_cmd(sw_cmd), .dip_cmd(dip_cmd),
    .key_in(key_in), .power_switch_in(power_switch_in), .dip_power_in(dip_power_in));
  // Short sample tick keeps the 2 s hold at 800 cycles
  bsc_regs #(.SAMPLE_CYCLES(4)) uut (.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req),
    .rdata(rdata), .key_in(key_in), .power_switch_in(power_switch_in),
    .dip_power_in(dip_power_in), .irq(irq), .system_power_on(system_power_on),
    .indicator_lamp_n(indicator_lamp_n), .front_light_off(front_light_off),
    .system_restart(system_restart), .switch_reset_scope(switch_reset_scope),
    .key_pattern(key_pattern));
  // ==========================================================
  // Tasks
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_out
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    exp_q.push_back(e);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
  endtask : rd
  task automatic idle(input int n);
    @(posedge core_clk);
    bus_req <= '0;
    repeat (n + 1) @(posedge core_clk);
  endtask : idle
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  // Bounded wait on irq or on system power
  task automatic wait_for(input logic pwr, input int lim);
    int i;
    i = 0;
    while (((pwr ? system_power_on : irq) !== 1'b1) && i < lim) begin
      @(posedge core_clk);
      i++;
    end
    if (i >= lim) begin
      errors++;
      $display("MISMATCH t=%0t wait got=%h exp=%h", $time, 1'b0, 1'b1);
      final_report();
    end
  endtask : wait_for
  // Read data stands only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (pend && exp_q.size() > 0)
      cmp_out(rdata, exp_q.pop_front());
    pend <= bus_req.rd;
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    idle(4);
    rd(8'h70, 8'h01);
    rd(8'h71, 8'h01);
    rd(8'h90, 8'h00);
    rd(8'ha0, 8'h01);
    rd(8'ha1, 8'h01);
    rd(8'ha2, 8'h02);
    rd(8'h33, 8'h00);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(8'ha0, seed);
      rd(8'ha0, seed);
    end
    wr(8'ha1, 8'hfe);
    rd(8'ha1, 8'h00);
    wr(8'ha2, 8'h01);
    rd(8'ha2, 8'h01);
    wr(8'ha2, 8'hfe);
    rd(8'ha2, 8'h02);
    idle(1);
    cmp_out(indicator_lamp_n, seed);
    cmp_out({6'h00, switch_reset_scope, front_light_off}, 8'h02);
    $display("registers done");
    wr(8'h61, 8'h00);
    wr(8'h60, 8'h07);
    for (int i = 0; i < 3; i++) begin
      key_cmd <= kseq[i];
      idle(0);
      wait_for(1'b0, 200);
      rd(8'h62, kflag[i]);
      rd(8'h64, kpat[i]);
      cmp_out(key_pattern[7:0], kpat[i]);
      rd(8'h90, 8'h04);
      wr(8'h62, 8'h00);
      wr(8'h90, 8'h00);
      idle(2);
      cmp_out({7'h00, irq}, 8'h00);
      rd(8'h90, 8'h00);
    end
    wr(8'h61, 8'h01);
    wr(8'h60, 8'h09);
    key_cmd <= 7'h40;
    idle(0);
    wait_for(1'b0, 200);
    rd(8'h62, 8'h0a);
    rd(8'h65, 8'h04);
    cmp_out(key_pattern[15:8], 8'h04);
    key_cmd <= 7'h00;
    idle(40);
    wr(8'h62, 8'h00);
    $display("keys done");
    wr(8'h60, 8'h10);
    sw_cmd <= 1'b1;
    idle(0);
    wait_for(1'b0, 1000);
    sw_cmd <= 1'b0;
    idle(10);
    cmp_out({7'h00, system_power_on}, 8'h00);
    rd(8'h62, 8'h10);
    rd(8'h90, 8'h04);
    wr(8'h62, 8'h00);
    wr(8'h90, 8'h00);
    sw_cmd <= 1'b1;
    idle(0);
    wait_for(1'b1, 1000);
    sw_cmd <= 1'b0;
    wr(8'h70, 8'h00);
    idle(1);
    cmp_out({7'h00, system_power_on}, 8'h00);
    $display("power done");
    dip_cmd <= 1'b0;
    nrst <= 1'b0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    idle(10);
    cmp_out({7'h00, system_power_on}, 8'h00);
    $display("strap done");
    final_report();
  end
endmodule : bsc_regs_tb
`default_nettype wire
